// ===== shared/irsp_map.svh
// constants of the two-wire register slave port: offsets, codes, timing
// assumes one system clock that is far faster than the serial clock
`ifndef IRSP_MAP_SVH
`define IRSP_MAP_SVH

`define IRSP_SLAVE_ADDR 7'h30
`define IRSP_RW_WRITE 1'b0
`define IRSP_RW_READ 1'b1
`define IRSP_OFS_CHIP_ID 8'h00
`define IRSP_OFS_REVISION 8'h01
`define IRSP_RO_COUNT 8'h02
`define IRSP_REV_RSVD 4'h0
`define IRSP_PTR_RST 8'h00
`define IRSP_BYTE_BITS 4'h8
`define IRSP_PTR_STEP 8'h01
`define IRSP_MCLK_HZ 100000000
`define IRSP_STD_HZ 100000
`define IRSP_FAST_HZ 400000
`define IRSP_FAST_HALF_CYC ((`IRSP_MCLK_HZ / `IRSP_FAST_HZ) / 2)
`define IRSP_MIN_HALF_CYC 4

`endif

// ===== shared/irsp_pkg.sv
// types of the two-wire register slave port
// assumes irsp_map.svh holds the numbers
package irsp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_PTR = 3'b010,
      ST_DATA = 3'b011,
      ST_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_RACK = 3'b110,
      ST_IGNORE = 3'b111
   } irsp_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } irsp_wr_t;

   typedef struct packed {
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic scl_d;
      logic sda_d;
      irsp_state_t st;
      irsp_state_t nx;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic nak;
      logic sda_oe;
      logic scl_oe;
      logic stall;
      irsp_wr_t [1:0] fq;
      logic [1:0] fv;
   } irsp_st_t;

endpackage

// ===== rtl/irsp_port.sv
// two-wire serial slave port giving a bus master access to byte registers
// assumes scl and sda arrive unsynchronised from open-drain pins
`timescale 1ns/100ps
`include "irsp_map.svh"

module irsp_port
   import irsp_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = `IRSP_SLAVE_ADDR,
   // arbitrary identification values
   parameter logic [7:0] CHIP_ID = 8'hA5,
   parameter logic [3:0] REVISION = 4'h1
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output irsp_wr_t wr_o,
   output logic [7:0] rd_addr_o,
   input wire logic [7:0] rd_data_i
);

   // sync latency needs a few system clocks per serial half period
   generate
      if (`IRSP_FAST_HALF_CYC < `IRSP_MIN_HALF_CYC) begin : g_chk
         $error("system clock too slow for fast-mode serial clock");
      end
   endgenerate

   localparam irsp_st_t ST_RST = '{
      scl_sy: 2'h3,
      sda_sy: 2'h3,
      scl_d: 1'b1,
      sda_d: 1'b1,
      st: ST_IDLE,
      nx: ST_IDLE,
      bits: 4'h0,
      sh: 8'h00,
      ptr: `IRSP_PTR_RST,
      nak: 1'b0,
      sda_oe: 1'b0,
      scl_oe: 1'b0,
      stall: 1'b0,
      fq: '0,
      fv: 2'h0
   };

   irsp_st_t s;
   irsp_st_t n;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic pop;
   logic push;
   logic full;
   logic wr_ro;
   logic [7:0] txb;
   irsp_wr_t wnew;

   // only the second stage of each synchroniser is looked at
   assign scl = s.scl_sy[1];
   assign sda = s.sda_sy[1];
   assign rise = scl & ~s.scl_d;
   assign fall = ~scl & s.scl_d;
   assign start = scl & s.scl_d & s.sda_d & ~sda;
   assign stop = scl & s.scl_d & ~s.sda_d & sda;
   assign full = s.fv[1];
   assign pop = s.fv[0] & wr_ready_i;
   assign wr_ro = s.ptr < `IRSP_RO_COUNT;
   assign wnew = '{addr: s.ptr, data: s.sh};

   // read source: two fixed registers, the rest from outside
   always_comb begin
      case (s.ptr)
         `IRSP_OFS_CHIP_ID: txb = CHIP_ID;
         `IRSP_OFS_REVISION: txb = {`IRSP_REV_RSVD, REVISION};
         default: txb = rd_data_i;
      endcase
   end

   // put a byte on the wire, msb first, and advance the pointer
   function automatic irsp_st_t load_tx(irsp_st_t x, logic [7:0] b);
      x.sh = b;
      x.ptr = x.ptr + `IRSP_PTR_STEP;
      x.sda_oe = ~b[7];
      x.bits = 4'h0;
      x.st = ST_TX;
      return x;
   endfunction

   always_comb begin
      n = s;
      push = 1'b0;
      n.scl_sy = {s.scl_sy[0], scl_i};
      n.sda_sy = {s.sda_sy[0], sda_i};
      n.scl_d = scl;
      n.sda_d = sda;
      if (pop) begin
         n.fq[0] = s.fq[1];
         n.fv[0] = s.fv[1];
         n.fv[1] = 1'b0;
      end
      if (start) begin
         // a repeated start restarts just like a first one
         n.st = ST_ADDR;
         n.bits = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
      end else if (s.stall) begin
         // scl held low until the buffer has room, so no byte is lost
         if (!full) begin
            push = 1'b1;
            n.stall = 1'b0;
            // scl stays held here; ST_ACK frees it a cycle later
            n.ptr = s.ptr + `IRSP_PTR_STEP;
            n.sda_oe = 1'b1;
            n.st = ST_ACK;
            n.nx = ST_DATA;
         end
      end else begin
         case (s.st)
            ST_ADDR, ST_PTR, ST_DATA: begin
               if (rise) begin
                  n.sh = {s.sh[6:0], sda};
                  n.bits = s.bits + 4'h1;
               end else if (fall && s.bits == `IRSP_BYTE_BITS) begin
                  n.bits = 4'h0;
                  case (s.st)
                     ST_ADDR: begin
                        if (s.sh[7:1] == SLAVE_ADDR) begin
                           n.sda_oe = 1'b1;
                           n.st = ST_ACK;
                           if (s.sh[0] == `IRSP_RW_READ) begin
                              n.nx = ST_TX;
                           end else begin
                              n.nx = ST_PTR;
                           end
                        end else begin
                           n.st = ST_IGNORE;
                        end
                     end
                     ST_PTR: begin
                        n.ptr = s.sh;
                        n.sda_oe = 1'b1;
                        n.st = ST_ACK;
                        n.nx = ST_DATA;
                     end
                     default: begin
                        if (wr_ro) begin
                           // read-only target: ack, drop, still advance
                           n.ptr = s.ptr + `IRSP_PTR_STEP;
                           n.sda_oe = 1'b1;
                           n.st = ST_ACK;
                           n.nx = ST_DATA;
                        end else if (full) begin
                           n.stall = 1'b1;
                           n.scl_oe = 1'b1;
                        end else begin
                           push = 1'b1;
                           n.ptr = s.ptr + `IRSP_PTR_STEP;
                           n.sda_oe = 1'b1;
                           n.st = ST_ACK;
                           n.nx = ST_DATA;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               // sda is set up a cycle before a stretched scl is let go
               n.scl_oe = 1'b0;
               // ack held until scl falls again, covering its high phase
               if (fall) begin
                  n.bits = 4'h0;
                  if (s.nx == ST_TX) begin
                     n = load_tx(n, txb);
                  end else begin
                     n.sda_oe = 1'b0;
                     n.st = s.nx;
                  end
               end
            end
            ST_TX: begin
               if (rise) begin
                  n.bits = s.bits + 4'h1;
               end else if (fall) begin
                  if (s.bits == `IRSP_BYTE_BITS) begin
                     n.sda_oe = 1'b0;
                     n.st = ST_RACK;
                  end else begin
                     n.sh = {s.sh[6:0], 1'b0};
                     n.sda_oe = ~s.sh[6];
                  end
               end
            end
            ST_RACK: begin
               if (rise) begin
                  n.nak = sda;
               end else if (fall) begin
                  if (s.nak) begin
                     n.st = ST_IGNORE;
                  end else begin
                     n = load_tx(n, txb);
                  end
               end
            end
            ST_IGNORE: begin
               n.sda_oe = 1'b0;
            end
            default: begin
               n.st = ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
      if (push) begin
         if (n.fv[0]) begin
            n.fq[1] = wnew;
            n.fv[1] = 1'b1;
         end else begin
            n.fq[0] = wnew;
            n.fv[0] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   // open-drain: the driven level is always low
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sda_o <= 1'b0;
         scl_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         scl_o <= 1'b0;
      end
   end

   assign sda_oe_o = s.sda_oe;
   assign scl_oe_o = s.scl_oe;
   assign wr_valid_o = s.fv[0];
   assign wr_o = s.fq[0];
   assign rd_addr_o = s.ptr;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   a_start_opens_addr: assert property (
      start |=> s.st == ST_ADDR && s.bits == 4'h0 && !s.sda_oe)
      else $error("start did not open address phase");

   a_stop_goes_idle: assert property (
      stop && !start |=> s.st == ST_IDLE && !sda_oe_o)
      else $error("stop did not end transfer");

   a_sda_scl_low: assert property (
      $changed(s.sda_oe) |-> !$past(scl) || $past(start) || $past(stop))
      else $error("sda changed while scl high");

   a_addr_ack_match: assert property (
      !start && !stop && !s.stall && s.st == ST_ADDR && fall &&
      s.bits == `IRSP_BYTE_BITS |=>
      (s.sda_oe == ($past(s.sh[7:1]) == SLAVE_ADDR)))
      else $error("address ack does not follow match");

   a_ignore_quiet: assert property (
      s.st == ST_IGNORE && !start |=> !sda_oe_o)
      else $error("sda driven after mismatch or nack");

   a_ptr_loaded: assert property (
      !start && !stop && s.st == ST_PTR && fall &&
      s.bits == `IRSP_BYTE_BITS |=> s.ptr == $past(s.sh) ##0 s.sda_oe)
      else $error("pointer byte not taken");

   a_data_advance: assert property (
      !start && !stop && !s.stall && s.st == ST_DATA && fall &&
      s.bits == `IRSP_BYTE_BITS && (wr_ro || !full) |=>
      s.ptr == $past(s.ptr) + `IRSP_PTR_STEP && s.st == ST_ACK)
      else $error("data byte did not advance pointer");

   a_nack_release: assert property (
      !start && !stop && s.st == ST_RACK && fall && s.nak |=>
      !sda_oe_o [*2])
      else $error("sda not released after nack");

   a_ro_untouched: assert property (
      push |-> !wr_ro && !full)
      else $error("write to read-only register or full buffer");

   a_ack_holds: assert property (
      s.st == ST_ACK && rise |-> s.sda_oe ##1 s.sda_oe || start || stop)
      else $error("ack not held through high phase");

   a_stretch_order: assert property (
      s.stall && !full |=> s.sda_oe && s.scl_oe ##1 !s.scl_oe)
      else $error("scl freed before ack was set up");

   a_stretch_cause: assert property (
      $rose(s.scl_oe) |-> $past(full))
      else $error("clock held without a full buffer");

   a_rx_shift: assert property (
      !start && !stop && !s.stall && rise &&
      (s.st == ST_ADDR || s.st == ST_PTR || s.st == ST_DATA) |=>
      s.sh == {$past(s.sh[6:0]), $past(sda)})
      else $error("received bit not shifted in at the bottom");

   a_tx_load: assert property (
      !start && !stop && !s.stall && s.st == ST_ACK && s.nx == ST_TX &&
      fall |=> s.st == ST_TX && s.sh == $past(txb) &&
      s.ptr == $past(s.ptr) + `IRSP_PTR_STEP)
      else $error("read byte not loaded from pointer");

   a_tx_release: assert property (
      !start && !stop && s.st == ST_TX && fall &&
      s.bits == `IRSP_BYTE_BITS |=> s.st == ST_RACK && !s.sda_oe)
      else $error("sda not freed for the master ack");

   a_rack_sample: assert property (
      !start && !stop && s.st == ST_RACK && rise |=> s.nak == $past(sda))
      else $error("master ack not sampled");

   a_wr_hold: assert property (
      wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o))
      else $error("write entry lost while consumer stalled");

   a_ro_dropped: assert property (
      !start && !stop && !s.stall && s.st == ST_DATA && fall &&
      s.bits == `IRSP_BYTE_BITS && wr_ro |-> !push ##1 s.sda_oe)
      else $error("read-only register write reached the buffer");

endmodule

// ===== test/irsp_master.sv
// two-wire bus master model driving the port's serial pins
// assumes open-drain wires with pull-ups, built by the bench
`timescale 1ns/100ps

module irsp_master (
   input wire logic mclk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_pull_o,
   output logic sda_pull_o,
   output logic hang_o
);
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
      hang_o = 1'b0;
   end

   // 4 cycles per half period gives the 80 ns serial clock
   task automatic half();
      repeat (4) @(posedge mclk_i);
   endtask

   // release scl and wait out any stretching, bounded
   task automatic scl_hi();
      int n;
      scl_pull_o <= 1'b0;
      n = 0;
      do begin
         half();
         n++;
      end while (scl_i !== 1'b1 && n < 200);
      if (scl_i !== 1'b1) hang_o <= 1'b1;
   endtask

   task automatic start();
      @(posedge mclk_i);
      sda_pull_o <= 1'b0;
      half();
      scl_hi();
      sda_pull_o <= 1'b1;
      half();
      scl_pull_o <= 1'b1;
   endtask

   task automatic stop();
      @(posedge mclk_i);
      sda_pull_o <= 1'b1;
      half();
      scl_hi();
      sda_pull_o <= 1'b0;
      half();
   endtask

   // data moves only while scl is low, one pulse per bit
   task automatic bit_x(input logic b, output logic r);
      @(posedge mclk_i);
      sda_pull_o <= !b;
      // low phase is the edge above plus three, matching the high phase
      repeat (3) @(posedge mclk_i);
      scl_hi();
      r = sda_i;
      scl_pull_o <= 1'b1;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask

   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(!ack, r);
   endtask
endmodule

// ===== test/tb_i2c_register_slave_port.sv
// self-checking bench of the two-wire register slave port
// assumes irsp_master as bus master and far registers as a fixed pattern
`timescale 1ns/100ps

module tb_i2c_register_slave_port;
   import irsp_pkg::*;
   logic mclk_i, rst_i, wr_ready_i, scl_o, scl_oe_o, sda_o, sda_oe_o;
   logic wr_valid_o, scl_pull, sda_pull, stretch_seen, ign_ack, m_hang;
   logic scl_w, sda_w;
   irsp_wr_t wr_o;
   logic [7:0] rd_addr_o, rd_data_i;
   irsp_wr_t got[$];
   int n_errors, total_checks;

   assign scl_w = scl_oe_o ? (scl_o & !scl_pull) : !scl_pull;
   assign sda_w = sda_oe_o ? (sda_o & !sda_pull) : !sda_pull;
   assign rd_data_i = rd_addr_o ^ 8'h3C;

   irsp_port uut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o),
      .wr_ready_i(wr_ready_i), .wr_o(wr_o), .rd_addr_o(rd_addr_o),
      .rd_data_i(rd_data_i));
   irsp_master m (.mclk_i(mclk_i), .scl_i(scl_w), .sda_i(sda_w),
      .scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .hang_o(m_hang));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) got.push_back(wr_o);
      if (rst_i === 1'b1) begin
         stretch_seen <= 1'b0;
      end else if (scl_oe_o === 1'b1) begin
         stretch_seen <= 1'b1;
      end
   end

   task automatic end_sim();
      chk_ack("master clock wait", 1'b0, m_hang);
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string w, input logic [15:0] e,
      input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic chk_ack(input string w, input logic e, input logic s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %b seen %b", w, e, s);
      end
   endtask

   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      if (a == 8'h00) return 8'hA5;
      if (a == 8'h01) return 8'h01;
      return a ^ 8'h3C;
   endfunction

   task automatic send_addr(input logic [7:0] a, input logic e);
      logic ack;
      m.start();
      m.wbyte(a, ack);
      chk_ack("address ack", e, ack);
   endtask

   task automatic reg_write(input logic [7:0] p, input logic [31:0] d,
      input int n);
      logic ack;
      send_addr(8'h60, 1'b1);
      m.wbyte(p, ack);
      chk_ack("pointer ack", 1'b1, ack);
      for (int i = 0; i < n; i++) begin
         m.wbyte(d[31-8*i -: 8], ack);
         chk_ack("data ack", 1'b1, ack);
      end
   endtask

   task automatic reg_read(input logic [7:0] p, input int n);
      logic [7:0] v;
      send_addr(8'h61, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.rbyte(i < n - 1, v);
         chk("read data", {8'h00, exp_reg(p + 8'(i))}, {8'h00, v});
      end
      repeat (6) @(posedge mclk_i);
      chk_ack("sda after nack", 1'b1, sda_w);
      m.stop();
   endtask

   initial begin
      repeat (100000) @(posedge mclk_i);
      n_errors++;
      $display("wrong value run time expected done seen hang");
      end_sim();
   end

   initial begin
      rst_i = 1'b1;
      wr_ready_i = 1'b1;
      n_errors = 0;
      total_checks = 0;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      chk("pointer reset", 16'h0000, {8'h00, rd_addr_o});
      reg_write(8'h00, 32'h0, 0);
      reg_read(8'h00, 2);
      $display("test identification done");
      reg_write(8'h00, 32'h55667700, 3);
      m.stop();
      chk("pointer after write", 16'h0003, {8'h00, rd_addr_o});
      chk("entries", 16'h0001, 16'(got.size()));
      chk("entry", 16'h0277, got.pop_front());
      reg_write(8'h00, 32'h0, 0);
      reg_read(8'h00, 2);
      $display("test read-only writes done");
      // stalled consumer forces clock stretching, nothing is lost
      wr_ready_i <= 1'b0;
      fork
         begin
            reg_write(8'h0A, 32'h11223344, 4);
            m.stop();
         end
         begin
            repeat (500) @(posedge mclk_i);
            wr_ready_i <= 1'b1;
         end
      join
      chk_ack("stretch", 1'b1, stretch_seen);
      chk("entries", 16'h0004, 16'(got.size()));
      for (int i = 0; i < 4; i++) begin
         chk("entry", {8'h0A + 8'(i), 8'h11 * 8'(i + 1)}, got[i]);
      end
      got.delete();
      $display("test buffer stall done");
      reg_read(8'h0E, 3);
      $display("test current pointer read done");
      send_addr(8'h62, 1'b0);
      m.wbyte(8'h00, ign_ack);
      chk_ack("ignored byte ack", 1'b0, ign_ack);
      m.stop();
      chk("pointer kept", 16'h0011, {8'h00, rd_addr_o});
      $display("test foreign address done");
      end_sim();
   end
endmodule
